// >>> hw/htdc_pkg.sv
// Functional notes
// - modes 00/01: switches follow manual bits
// - modes 10/11: manual bits ignored
// - switch state kept in standby domain
// - button detect only after switches configured
// - comparators 10 give type 1, 01 type 2
// - comparators 00 type 3, 11 type 4
// - types 1/4 close ref,filt,gnd@3, bias@4
// - type 2 mirrored; type 3 no bias
// - recognise mic short button press
// - wake output on plug change or button
// - three resets of decreasing reach
// - maskable interrupts, debounced status
// - shadow registers accumulate events between reads
// - latchable copies carry config to standby
// - bias output high impedance on unplug
// - standby runs with core supply absent
package htdc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ        = 250;
    localparam int SETTLE_TIME_NS = 1000;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W       = 9;
    localparam int DBNC_TIME_US   = 1000;
    localparam int DBNC_CYCLES    = DBNC_TIME_US * CLK_MHZ;
    localparam int DBNC_W         = 18;
    localparam int SYNC_W         = 5;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_SWITCH = 8'h04;
    localparam logic [7:0]  REG_STATUS = 8'h08;
    localparam logic [7:0]  REG_EVENT  = 8'h0c;
    localparam logic [7:0]  REG_MASK   = 8'h10;
    localparam logic [7:0]  REG_COUNT  = 8'h14;
    localparam logic [7:0]  REG_RESET  = 8'h18;

    // control fields
    localparam int CTRL_HDC_LSB    = 0;
    localparam int CTRL_INV_BIT    = 2;
    localparam int CTRL_PDN_BIT    = 3;
    localparam int CTRL_MODE_LSB   = 4;
    localparam int CTRL_MICOFF_BIT = 6;
    localparam int CTRL_SENSE_BIT  = 7;
    localparam int CTRL_LATCH_BIT  = 8;
    localparam int CTRL_START_BIT  = 9;
    localparam logic [7:0] CTRL_RST = 8'h48;
    localparam logic [7:0] SW_RST   = 8'h00;

    // status fields
    localparam int STAT_TYPE_LSB = 0;
    localparam int STAT_DONE_BIT = 3;
    localparam int STAT_PLUG_BIT = 4;
    localparam int STAT_BTN_BIT  = 5;
    localparam int STAT_HIZ_BIT  = 6;
    localparam int STAT_CFG_BIT  = 7;
    localparam int STAT_SW_LSB   = 8;
    localparam int STAT_CORE_BIT = 16;

    // events
    localparam int         EV_W      = 4;
    localparam int         EV_PLUG   = 0;
    localparam int         EV_BUTTON = 1;
    localparam int         EV_DONE   = 2;
    localparam int         EV_HIZ    = 3;
    localparam logic [3:0] MASK_RST  = 4'hf;

    // soft reset kinds written to the reset register
    localparam logic [1:0] RST_STATUS  = 2'h1;
    localparam logic [1:0] RST_DETECT  = 2'h2;
    localparam logic [1:0] RST_CONTROL = 2'h3;

    // jack types and switch patterns
    localparam logic [2:0] TYPE_NONE = 3'h0;
    localparam logic [2:0] TYPE_1    = 3'h1;
    localparam logic [2:0] TYPE_2    = 3'h2;
    localparam logic [2:0] TYPE_3    = 3'h3;
    localparam logic [2:0] TYPE_4    = 3'h4;
    // bit order: ref3 ref4 filt3 filt4 bias3 bias4 gnd3 gnd4 (lsb first)
    localparam logic [7:0] PAT_T1    = 8'h65;
    localparam logic [7:0] PAT_T2    = 8'h9a;
    localparam logic [7:0] PAT_T3    = 8'hcf;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_DECODE = 4'b0100,
        ST_DONE   = 4'b1000
    } htdc_state_t;

    // comparator pair to jack type
    function automatic logic [2:0] decode_type(input logic a, input logic b);
        unique case ({a, b})
            2'b10:   decode_type = TYPE_1;
            2'b01:   decode_type = TYPE_2;
            2'b00:   decode_type = TYPE_3;
            default: decode_type = TYPE_4;
        endcase
    endfunction

    // jack type to contact switch pattern
    function automatic logic [7:0] switch_pattern(input logic [2:0] t);
        unique case (t)
            TYPE_2:  switch_pattern = PAT_T2;
            TYPE_3:  switch_pattern = PAT_T3;
            default: switch_pattern = PAT_T1;
        endcase
    endfunction

    // byte-lane merge of a write into a register
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] wr_v,
                                               input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            lane_merge[i*8 +: 8] = be[i] ? wr_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
    endfunction

endpackage

// >>> hw/htdc_debounce.sv
`timescale 1ns/1ps
module htdc_debounce
    import htdc_pkg::*;
#(
    parameter int CYCLES = DBNC_CYCLES
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_level,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic [DBNC_W-1:0] count;
    logic [DBNC_W-1:0] next_count;
    logic              stable;
    logic              next_stable;

    ////////////////////////////////////////////////////////////////////////////
    // only a level held for the full count is reported
    always_comb begin
        next_count  = '0;
        next_stable = stable;
        if (i_level != stable) begin
            if (count >= DBNC_W'(CYCLES - 1)) begin
                next_stable = i_level;
            end else begin
                next_count = count + DBNC_W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            count  <= '0;
            stable <= 1'b0;
        end else begin
            count  <= next_count;
            stable <= next_stable;
        end
    end

    assign o_level = stable;
    assign o_rise  = next_stable & ~stable;
    assign o_fall  = ~next_stable & stable;
endmodule

// >>> hw/htdc_top.sv
`timescale 1ns/1ps
module htdc_top
    import htdc_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = htdc_pkg::DBNC_CYCLES
) (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst,
    // avalon-mm slave
    input  wire logic [htdc_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                      i_avs_read,
    input  wire logic                      i_avs_write,
    input  wire logic [31:0]               i_avs_writedata,
    input  wire logic [3:0]                i_avs_byteenable,
    output logic      [31:0]               o_avs_readdata,
    output logic                           o_avs_waitrequest,
    // analogue side, asynchronous
    input  wire logic                      i_cmp_a,
    input  wire logic                      i_cmp_b,
    input  wire logic                      i_plug_sense,
    input  wire logic                      i_mic_short,
    input  wire logic                      i_core_supply_ok,
    output logic      [7:0]                o_switch,
    output logic                           o_detect_run,
    output logic                           o_bias_hiz,
    output logic                           o_capture_invert,
    output logic                           o_global_powerdown,
    output logic      [1:0]                o_detect_mode,
    output logic                           o_mic_level_detect_off,
    output logic                           o_bias_sense_on,
    output logic                           o_wake,
    output logic                           o_irq
);
    import htdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; stage one is read only by stage two
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {i_core_supply_ok, i_mic_short, i_plug_sense, i_cmp_b, i_cmp_a};
            sync2 <= sync1;
        end
    end

    logic cmp_a;
    logic cmp_b;
    logic core_ok;
    assign cmp_a   = sync2[0];
    assign cmp_b   = sync2[1];
    assign core_ok = sync2[4];

    ////////////////////////////////////////////////////////////////////////////
    // debounced plug and button levels
    logic plug_lvl;
    logic plug_rise;
    logic plug_fall;
    logic btn_lvl;
    logic btn_rise;

    htdc_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_plug_dbnc (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_level    (sync2[2]),
        .o_level    (plug_lvl),
        .o_rise     (plug_rise),
        .o_fall     (plug_fall)
    );

    htdc_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_btn_dbnc (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_level    (sync2[3]),
        .o_level    (btn_lvl),
        .o_rise     (btn_rise),
        .o_fall     ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait state, answer on the second edge
    logic        ack;
    logic        next_ack;
    logic        req;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [31:0] wr_ctrl;
    logic [31:0] wr_sw;

    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack;
    assign wr_go             = i_avs_write & ack;
    assign rd_go             = i_avs_read & ack;
    assign next_ack          = req & ~ack;

    ////////////////////////////////////////////////////////////////////////////
    // control state
    logic [7:0]      ctrl;
    logic [7:0]      next_ctrl;
    logic [7:0]      man_sw;
    logic [7:0]      next_man_sw;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] next_mask;
    logic            latch_cmd;
    logic            start_cmd;
    logic [1:0]      rst_kind;
    logic            rst_status;
    logic            rst_detect;
    logic            rst_control;
    logic            auto_mode;

    assign auto_mode = ctrl[CTRL_HDC_LSB + 1];

    always_comb begin
        wr_ctrl     = lane_merge({24'h0, ctrl}, i_avs_writedata, i_avs_byteenable);
        wr_sw       = lane_merge({24'h0, man_sw}, i_avs_writedata, i_avs_byteenable);
        rst_kind    = (wr_go && i_avs_address == REG_RESET && i_avs_byteenable[0])
                      ? i_avs_writedata[1:0] : 2'h0;
        rst_control = (rst_kind == RST_CONTROL);
        rst_detect  = rst_control || (rst_kind == RST_DETECT);
        rst_status  = rst_detect || (rst_kind == RST_STATUS);
        latch_cmd   = wr_go && i_avs_address == REG_CTRL && wr_ctrl[CTRL_LATCH_BIT];
        start_cmd   = wr_go && i_avs_address == REG_CTRL && wr_ctrl[CTRL_START_BIT];
        next_ctrl   = ctrl;
        next_man_sw = man_sw;
        next_mask   = mask;
        if (rst_control) begin
            next_ctrl   = CTRL_RST;
            next_man_sw = SW_RST;
            next_mask   = MASK_RST;
        end else if (wr_go) begin
            unique case (i_avs_address)
                REG_CTRL:   next_ctrl   = wr_ctrl[7:0];
                REG_SWITCH: next_man_sw = wr_sw[7:0];
                REG_MASK:   next_mask   = i_avs_byteenable[0] ? i_avs_writedata[EV_W-1:0] : mask;
                default:    next_ctrl   = ctrl;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ack    <= 1'b0;
            ctrl   <= CTRL_RST;
            man_sw <= SW_RST;
            mask   <= MASK_RST;
        end else begin
            ack    <= next_ack;
            ctrl   <= next_ctrl;
            man_sw <= next_man_sw;
            mask   <= next_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // automatic type detection; held idle without the core supply
    htdc_state_t         state;
    htdc_state_t         next_state;
    logic [SETTLE_W-1:0] settle;
    logic [SETTLE_W-1:0] next_settle;
    logic [2:0]          jack_type;
    logic [2:0]          next_jack_type;
    logic                done;
    logic                next_done;
    logic                apply_auto;

    always_comb begin
        next_state     = state;
        next_settle    = '0;
        next_jack_type = jack_type;
        next_done      = done;
        apply_auto     = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (auto_mode && (start_cmd || plug_rise)) begin
                    next_state = ST_SETTLE;
                    next_done  = 1'b0;
                end
            end
            ST_SETTLE: begin
                next_settle = settle + SETTLE_W'(1);
                if (settle == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                    next_state = ST_DECODE;
                end
            end
            ST_DECODE: begin
                next_jack_type = decode_type(cmp_a, cmp_b);
                next_state     = ST_DONE;
            end
            ST_DONE: begin
                apply_auto = 1'b1;
                next_done  = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        if (!core_ok || rst_detect || !auto_mode) begin
            next_state = ST_IDLE;
            apply_auto = 1'b0;
        end
        if (rst_detect) begin
            next_jack_type = TYPE_NONE;
            next_done      = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state     <= ST_IDLE;
            settle    <= '0;
            jack_type <= TYPE_NONE;
            done      <= 1'b0;
        end else begin
            state     <= next_state;
            settle    <= next_settle;
            jack_type <= next_jack_type;
            done      <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // standby copies: only the hard reset clears stby_cfg; a control reset drops to manual mode so stby_sw follows man_sw to zero, but the switches
    // keep their state through status and detect resets and core supply loss
    logic [7:0] stby_sw;
    logic [7:0] next_stby_sw;
    logic [7:0] stby_cfg;
    logic [7:0] next_stby_cfg;
    logic       sw_cfg;
    logic       next_sw_cfg;

    always_comb begin
        next_stby_sw  = stby_sw;
        next_stby_cfg = stby_cfg;
        next_sw_cfg   = sw_cfg;
        if (core_ok) begin
            if (apply_auto) begin
                next_stby_sw = switch_pattern(jack_type);
                next_sw_cfg  = 1'b1;
            end else if (!auto_mode) begin
                next_stby_sw = man_sw;
                next_sw_cfg  = (man_sw != 8'h00);
            end
            if (latch_cmd) begin
                next_stby_cfg = wr_ctrl[7:0];
            end
        end
        if (rst_detect) begin
            next_sw_cfg = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            stby_sw  <= SW_RST;
            stby_cfg <= CTRL_RST;
            sw_cfg   <= 1'b0;
        end else begin
            stby_sw  <= next_stby_sw;
            stby_cfg <= next_stby_cfg;
            sw_cfg   <= next_sw_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events, shadow count, bias hi-z, wake
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] next_events;
    logic [EV_W-1:0] ev_set;
    logic [7:0]      ev_count;
    logic [7:0]      next_ev_count;
    logic            hiz;
    logic            next_hiz;
    logic            wake;
    logic            next_wake;
    logic            btn_press;

    assign btn_press = btn_rise & sw_cfg;

    always_comb begin
        ev_set            = '0;
        ev_set[EV_PLUG]   = plug_rise | plug_fall;
        ev_set[EV_BUTTON] = btn_press;
        ev_set[EV_DONE]   = apply_auto;
        ev_set[EV_HIZ]    = plug_fall & ~hiz;
        next_events       = events;
        next_ev_count     = ev_count;
        if (wr_go && i_avs_address == REG_EVENT) begin
            next_events = events & ~(i_avs_writedata[EV_W-1:0] & {EV_W{i_avs_byteenable[0]}});
        end
        if (rd_go && i_avs_address == REG_COUNT) begin
            next_ev_count = 8'h00;
        end
        if (rst_status) begin
            next_events   = '0;
            next_ev_count = 8'h00;
        end
        next_events = next_events | ev_set;   // set wins over clear
        if (|ev_set && next_ev_count != 8'hff) begin
            next_ev_count = next_ev_count + 8'h01;
        end
        // a quiet bias on unplug avoids the pop; insert restores it
        next_hiz = hiz;
        if (plug_fall) begin
            next_hiz = 1'b1;
        end else if (plug_rise || rst_detect) begin
            next_hiz = 1'b0;
        end
        next_wake = wake;
        if (ev_set[EV_PLUG] || btn_press) begin
            next_wake = 1'b1;
        end else if (wr_go && i_avs_address == REG_EVENT) begin
            next_wake = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            events   <= '0;
            ev_count <= 8'h00;
            hiz      <= 1'b0;
            wake     <= 1'b0;
        end else begin
            events   <= next_events;
            ev_count <= next_ev_count;
            hiz      <= next_hiz;
            wake     <= next_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux, captured in the wait cycle; unmapped reads give zero
    always_comb begin
        next_rdata = rdata;
        if (i_avs_read && !ack) begin
            unique case (i_avs_address)
                REG_CTRL:   next_rdata = {24'h0, ctrl};
                REG_SWITCH: next_rdata = {24'h0, man_sw};
                REG_STATUS: next_rdata = {15'h0, core_ok, stby_sw, sw_cfg, hiz,
                                          btn_lvl, plug_lvl, done, jack_type};
                REG_EVENT:  next_rdata = {28'h0, events};
                REG_MASK:   next_rdata = {28'h0, mask};
                REG_COUNT:  next_rdata = {24'h0, ev_count};
                default:    next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_avs_readdata         = rdata;
    assign o_switch               = stby_sw;
    assign o_detect_run           = (state == ST_SETTLE) || (state == ST_DECODE);
    assign o_bias_hiz             = hiz;
    assign o_capture_invert       = ctrl[CTRL_INV_BIT];
    assign o_global_powerdown     = ctrl[CTRL_PDN_BIT];
    assign o_detect_mode          = stby_cfg[CTRL_MODE_LSB +: 2];
    assign o_mic_level_detect_off = stby_cfg[CTRL_MICOFF_BIT];
    assign o_bias_sense_on        = stby_cfg[CTRL_SENSE_BIT];
    assign o_wake                 = wake;
    assign o_irq                  = |(events & ~mask);
endmodule

// >>> bench/htdc_jack_model.sv
`timescale 1ns/1ps
module htdc_jack_model (
    input  wire logic       i_plugged,
    input  wire logic [2:0] i_kind,
    input  wire logic       i_press,
    output logic            o_cmp_a,
    output logic            o_cmp_b,
    output logic            o_plug_sense,
    output logic            o_mic_short
);
    // comparator pair per plug kind; an empty jack floats high on both
    always_comb begin
        o_cmp_a      = !i_plugged || i_kind == 3'h1 || i_kind == 3'h4;
        o_cmp_b      = !i_plugged || i_kind == 3'h2 || i_kind == 3'h4;
        o_plug_sense = i_plugged;
        o_mic_short  = i_plugged && i_press;
    end
endmodule

// >>> bench/htdc_chk.sv
`timescale 1ns/1ps
module htdc_chk (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic        o_avs_waitrequest,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        i_cmp_a,
    input wire logic        i_cmp_b,
    input wire logic [7:0]  o_switch,
    input wire logic        o_detect_run,
    input wire logic        o_wake
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // bus: exactly one wait state, read data held between reads
    property p_wait_first; $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest; endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state");
    property p_wait_one; o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait state too long");
    property p_rdata; !i_avs_read |=> $stable(o_avs_readdata); endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
    // detect run spans settle plus decode, switches frozen meanwhile
    property p_run; $rose(o_detect_run) |-> ##250 o_detect_run ##1 !o_detect_run; endproperty
    a_run: assert property (p_run) else $error("detect length wrong");
    property p_sw_hold; o_detect_run |=> $stable(o_switch); endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("switch moved in detect");
    // pattern applied one edge after detect ends
    property p_pat_a; $fell(o_detect_run) && i_cmp_a |=> o_switch == 8'h65; endproperty
    a_pat_a: assert property (p_pat_a) else $error("type 1 or 4 pattern");
    property p_pat_b; $fell(o_detect_run) && !i_cmp_a && i_cmp_b |=> o_switch == 8'h9a; endproperty
    a_pat_b: assert property (p_pat_b) else $error("type 2 pattern");
    property p_pat_c; $fell(o_detect_run) && !i_cmp_a && !i_cmp_b |=> o_switch == 8'hcf;
    endproperty
    a_pat_c: assert property (p_pat_c) else $error("type 3 pattern");
    property p_wake; o_wake && !i_avs_write |=> o_wake; endproperty
    a_wake: assert property (p_wake) else $error("wake dropped");
endmodule
bind htdc_top htdc_chk i_chk (.*);

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    import htdc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd_r = 1'b0;
    logic        wr_r = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic        plugged = 1'b1;
    logic [2:0]  kind = 3'h1;
    logic        press = 1'b0;
    logic        sup = 1'b1;
    logic [31:0] rdat, q;
    logic [7:0]  sw;
    logic [1:0]  dmode;
    logic        wreq, cmp_a, cmp_b, plug_s, mic_s, run, hiz, inv, pdn, mloff, sns, wake, irq;
    logic [7:0]  pat [1:4] = '{8'h65, 8'h9a, 8'hcf, 8'h65};
    int          miscompares = 0;
    int          checks = 0;

    always #2 clk = ~clk;

    htdc_top #(.DEBOUNCE_CYCLES(4)) i_dut (
        .i_core_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd_r),
        .i_avs_write(wr_r), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_cmp_a(cmp_a), .i_cmp_b(cmp_b),
        .i_plug_sense(plug_s), .i_mic_short(mic_s), .i_core_supply_ok(sup), .o_switch(sw),
        .o_detect_run(run), .o_bias_hiz(hiz), .o_capture_invert(inv),
        .o_global_powerdown(pdn), .o_detect_mode(dmode), .o_mic_level_detect_off(mloff),
        .o_bias_sense_on(sns), .o_wake(wake), .o_irq(irq));
    htdc_jack_model i_jack (.i_plugged(plugged), .i_kind(kind), .i_press(press),
        .o_cmp_a(cmp_a), .o_cmp_b(cmp_b), .o_plug_sense(plug_s), .o_mic_short(mic_s));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // request held until waitrequest is sampled low, then one idle edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        rd_r <= !w;
        wr_r <= w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // auto detect of one plug kind in auto mode m
    task automatic detect(input logic [2:0] t, input logic [31:0] m);
        kind <= t;
        cyc(4);
        bus(1'b1, REG_CTRL, 32'h40 | m);
        bus(1'b1, REG_CTRL, 32'h240 | m);
        wait (run === 1'b1);
        wait (run === 1'b0);
        cyc(2);
        chk("switch", {24'h0, pat[t]}, {24'h0, sw});
        bus(1'b0, REG_STATUS, 32'h0);
        chk("type", {29'h0, t}, {29'h0, q[2:0]});
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the roughly 1300 cycles the tests need
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end

    initial begin
        cyc(12);
        rst <= 1'b0;
        cyc(1);
        chk("powerdown", 32'h1, {31'h0, pdn});
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 32'h48, q);
        bus(1'b0, REG_MASK, 32'h0);
        chk("mask", 32'hf, q);
        bus(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
        // precharge through the filter and bias pairs, then the final pattern
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, REG_CTRL, 32'h40 | 32'(m));
            bus(1'b1, REG_SWITCH, 32'h3c);
            cyc(2);
            chk("precharge", 32'h3c, {24'h0, sw});
            bus(1'b1, REG_SWITCH, 32'h5a + 32'(m));
            cyc(2);
            chk("manual", 32'h5a + 32'(m), {24'h0, sw});
        end
        $display("test manual done");
        for (int t = 1; t < 5; t++) detect(3'(t), 32'(2 + t % 2));
        bus(1'b1, REG_SWITCH, 32'hff);
        cyc(2);
        chk("auto hold", {24'h0, pat[4]}, {24'h0, sw});
        $display("test detect done");
        bus(1'b1, REG_EVENT, 32'hf);
        chk("wake clear", 32'h0, {31'h0, wake});
        bus(1'b1, REG_RESET, {30'h0, RST_STATUS});
        // two separate presses must both be kept
        repeat (2) begin
            press <= 1'b1;
            cyc(20);
            press <= 1'b0;
            cyc(20);
        end
        chk("wake", 32'h1, {31'h0, wake});
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b0, REG_COUNT, 32'h0);
        chk("count", 32'h2, q);
        bus(1'b0, REG_EVENT, 32'h0);
        chk("event", 32'h2, q);
        bus(1'b1, REG_MASK, 32'hd);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, REG_EVENT, 32'h2);
        chk("irq clear", 32'h0, {31'h0, irq});
        $display("test events done");
        // latch carries mode, mic and sense bits to the standby outputs
        bus(1'b1, REG_CTRL, 32'h196);
        chk("standby", 32'h5, {28'h0, dmode, mloff, sns});
        chk("invert", 32'h1, {31'h0, inv});
        bus(1'b1, REG_RESET, {30'h0, RST_DETECT});
        bus(1'b0, REG_STATUS, 32'h0);
        chk("type cleared", 32'h0, {29'h0, q[2:0]});
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl kept", 32'h96, {24'h0, q[7:0]});
        chk("switch kept", {24'h0, pat[4]}, {24'h0, sw});
        // no detect start without the core supply
        sup <= 1'b0;
        cyc(4);
        bus(1'b1, REG_CTRL, 32'h296);
        chk("no supply", 32'h0, {31'h0, run});
        chk("switch frozen", {24'h0, pat[4]}, {24'h0, sw});
        sup <= 1'b1;
        $display("test standby done");
        plugged <= 1'b0;
        cyc(20);
        chk("bias hiz", 32'h1, {31'h0, hiz});
        bus(1'b1, REG_RESET, {30'h0, RST_CONTROL});
        bus(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", 32'h48, q);
        $display("test unplug done");
        end_of_test();
    end
endmodule
